// File: ees_pkg.sv
/*
  shared constants and types for the two-wire serial eeprom slave and its bus master.
  assumes both ends run on one 20 MHz aclk with a synchronous active-low reset.
*/
package ees_pkg;
  // ***************
  // clock and timing
  // ***************
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned PROG_NS = 10_000_000;
  localparam int unsigned PROG_CYC = PROG_NS / CLK_NS;
  localparam int unsigned SCL_QTR_NS = 650;
  localparam int unsigned SCL_QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;
  // ***************
  // device select decoding
  // ***************
  localparam logic [3:0] TYPE_MEM = 4'hA;
  localparam logic [3:0] TYPE_PROT = 4'h6;
  localparam logic [7:0] PROT_RST = 8'hFF;
  localparam int unsigned PROT_TB_BIT = 7;
  // ***************
  // controller registers
  // ***************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam int unsigned CMD_START_BIT = 8;
  localparam int unsigned CMD_STOP_BIT = 9;
  localparam int unsigned CMD_READ_BIT = 10;
  localparam int unsigned CMD_ACK_BIT = 11;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_NACK_BIT = 1;
  localparam int unsigned STAT_DONE_BIT = 2;
  localparam int unsigned STAT_RX_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ***************
  // state machines
  // ***************
  typedef enum logic [5:0] {
    D_IDLE = 6'b000001,
    D_DSEL = 6'b000010,
    D_ADDR = 6'b000100,
    D_WDATA = 6'b001000,
    D_RDATA = 6'b010000,
    D_RDONE = 6'b100000
  } ees_dstate_type;
  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_START = 5'b00010,
    H_BIT = 5'b00100,
    H_STOP = 5'b01000,
    H_DONE = 5'b10000
  } ees_hstate_type;
endpackage

// File: ees_link_if.sv
/*
  two-wire link between the bus master and the eeprom slave.
  assumes each end drives only its own enable; the wire is resolved here as open drain.
*/
`timescale 1ns/10ps
interface ees_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  wire sda;
  // pulled up unless an enabled driver pulls low
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport slave (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface

// File: ees_dev.sv
/*
  slave end of the two-wire serial eeprom: 256 bytes, page buffer, protect register.
  assumes aclk is far faster than scl; scl, sda and the strap pins are asynchronous.
*/
`timescale 1ns/10ps
// How it works
// - type 1010 selects array, 0110 protect register
// - select bits b3..b1 must equal chip selects
// - bytes shift msb first, b0 is direction
// - acknowledge written bytes on ninth clock
// - stop after master nack returns standby
// - stop after write starts programming cycle
// - start is sda fall with scl high
// - stop is sda rise with scl high
// - idle until start seen, except while programming
// - sample sda on scl rising edge
// - master changes sda only while scl low
// - transmitter releases sda, receiver acks ninth
// - write lock high blocks protected zone writes
// - write lock reads high when undriven
// - unprotected locations write regardless of lock
// - reset disables all operation and bus replies
// - array is 256 bytes, 8-bit address
// - byte writes and 16-byte page writes
// - sequential reads return consecutive bytes
// - direction bit 1 reads, 0 writes
// - unmatched select byte: silent, back to standby
// - protected write gets nack, location unchanged
module ees_dev #(
  parameter int unsigned PROG_CYC = ees_pkg::PROG_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // two-wire link
  ees_link_if.slave link,
  // strap pins
  input wire logic [2:0] chip_select_inputs,
  input wire logic write_lock_pin,
  // status
  output logic prog_busy
);
  import ees_pkg::*;
  localparam int CW = $clog2(PROG_CYC + 1);

  // ***************
  // state
  // ***************
  ees_dstate_type state_r;
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic [1:0] wl_s_r;
  logic [2:0] cs_s0_r;
  logic [2:0] cs_s1_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] out_r;
  logic [7:0] addr_r;
  logic [7:0] prot_r;
  logic [7:0] prot_buf_r;
  logic [15:0] page_mask_r;
  logic prot_pend_r;
  logic tgt_prot_r;
  logic rd_r;
  logic mnack_r;
  logic sda_oe_r;
  logic sda_o_r;
  logic busy_r;
  logic [CW-1:0] cnt_r;
  logic [7:0] mem [0:255];
  logic [7:0] page_buf [0:15];

  // ***************
  // decoding
  // ***************
  wire scl_hi = scl_s_r[1];
  wire sda_in = sda_s_r[1];
  wire scl_rise = scl_s_r[1] && !scl_s_r[2];
  wire scl_fall = !scl_s_r[1] && scl_s_r[2];
  wire start_det = scl_hi && scl_s_r[2] && !sda_in && sda_s_r[2];
  wire stop_det = scl_hi && scl_s_r[2] && sda_in && !sda_s_r[2];
  wire byte_evt = scl_fall && (bit_cnt_r == 4'h7);
  wire ack_end = scl_fall && (bit_cnt_r == 4'h8);
  wire type_mem = (shift_r[7:4] == TYPE_MEM);
  wire type_prot = (shift_r[7:4] == TYPE_PROT);
  wire cs_match = (shift_r[3:1] == cs_s1_r);
  wire sel_hit = (type_mem || type_prot) && cs_match && !busy_r;
  // a floating pin is pulled up outside, and the sync chain resets high
  wire lock_hi = wl_s_r[1];
  wire row_low = (addr_r[7:4] <= prot_r[3:0]);
  wire in_zone = prot_r[PROT_TB_BIT] ? !row_low : row_low;
  wire wr_block = lock_hi && (tgt_prot_r || in_zone);
  wire buf_we = byte_evt && (state_r == D_WDATA) && !wr_block && !tgt_prot_r;
  wire prog_go = stop_det && (state_r == D_WDATA) && ((|page_mask_r) || prot_pend_r);
  wire [7:0] rd_byte = tgt_prot_r ? prot_r : mem[addr_r];

  assign link.s_sda_oe = sda_oe_r;
  assign link.s_sda_o = sda_o_r;
  assign prog_busy = busy_r;

  // ***************
  // input synchronisers
  // ***************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      wl_s_r <= 2'h3;
      cs_s0_r <= 3'h0;
      cs_s1_r <= 3'h0;
    end else begin
      scl_s_r <= {scl_s_r[1:0], link.scl};
      sda_s_r <= {sda_s_r[1:0], link.sda};
      wl_s_r <= {wl_s_r[0], write_lock_pin};
      cs_s0_r <= chip_select_inputs;
      cs_s1_r <= cs_s0_r;
    end
  end

  // ***************
  // programming timer
  // ***************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      prot_r <= PROT_RST;
    end else if (prog_go) begin
      busy_r <= 1'b1;
      cnt_r <= CW'(PROG_CYC);
      if (prot_pend_r) begin
        prot_r <= prot_buf_r;
      end
    end else if (busy_r) begin
      cnt_r <= cnt_r - CW'(1);
      if (cnt_r == CW'(1)) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ***************
  // array and page buffer
  // ***************
  // the page is copied in one edge; the timer only models the busy window
  always_ff @(posedge aclk) begin
    if (buf_we) begin
      page_buf[addr_r[3:0]] <= shift_r;
    end
    if (prog_go) begin
      for (int i = 0; i < 16; i++) begin
        if (page_mask_r[i]) begin
          mem[{addr_r[7:4], 4'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // ***************
  // bit and byte engine
  // ***************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= D_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      out_r <= 8'h00;
      addr_r <= 8'h00;
      prot_buf_r <= 8'h00;
      page_mask_r <= 16'h0000;
      prot_pend_r <= 1'b0;
      tgt_prot_r <= 1'b0;
      rd_r <= 1'b0;
      mnack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_o_r <= 1'b0;
    end else if (start_det) begin
      state_r <= D_DSEL;
      // the scl fall that closes a start is no data bit; it wraps this to zero
      bit_cnt_r <= 4'hF;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      if (prog_go) begin
        page_mask_r <= 16'h0000;
        prot_pend_r <= 1'b0;
      end
      // a stop in mid read is not an end of read; only a nack or a new start ends it
      if (state_r != D_RDATA) begin
        state_r <= D_IDLE;
      end
    end else if (state_r != D_IDLE) begin
      if (scl_rise && (bit_cnt_r < 4'h8)) begin
        shift_r <= {shift_r[6:0], sda_in};
      end
      if (scl_rise && (bit_cnt_r == 4'h8) && (state_r == D_RDATA)) begin
        mnack_r <= sda_in;
      end
      if (scl_fall) begin
        bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
      end
      if (byte_evt) begin
        case (state_r)
          D_DSEL: begin
            sda_oe_r <= sel_hit;
            tgt_prot_r <= type_prot;
            rd_r <= shift_r[0];
            if (!sel_hit) begin
              state_r <= D_IDLE;
            end else if (!shift_r[0]) begin
              page_mask_r <= 16'h0000;
              prot_pend_r <= 1'b0;
            end
          end
          D_ADDR: begin
            addr_r <= shift_r;
            sda_oe_r <= 1'b1;
          end
          D_WDATA: begin
            sda_oe_r <= !wr_block;
            if (!wr_block && tgt_prot_r) begin
              prot_buf_r <= shift_r;
              prot_pend_r <= 1'b1;
            end
            if (!wr_block && !tgt_prot_r) begin
              page_mask_r[addr_r[3:0]] <= 1'b1;
            end
            // only the low nibble counts, so a long page wraps in its row
            addr_r <= {addr_r[7:4], addr_r[3:0] + 4'h1};
          end
          default: begin
            sda_oe_r <= 1'b0;
          end
        endcase
      end else if (ack_end) begin
        sda_oe_r <= 1'b0;
        case (state_r)
          D_DSEL: begin
            if (rd_r) begin
              state_r <= D_RDATA;
              out_r <= rd_byte;
              sda_oe_r <= !rd_byte[7];
              addr_r <= tgt_prot_r ? addr_r : addr_r + 8'h01;
            end else begin
              state_r <= D_ADDR;
            end
          end
          D_ADDR: begin
            state_r <= D_WDATA;
          end
          D_RDATA: begin
            if (mnack_r) begin
              state_r <= D_RDONE;
            end else begin
              out_r <= rd_byte;
              sda_oe_r <= !rd_byte[7];
              addr_r <= tgt_prot_r ? addr_r : addr_r + 8'h01;
            end
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end else if (scl_fall && (state_r == D_RDATA)) begin
        out_r <= {out_r[6:0], 1'b0};
        sda_oe_r <= !out_r[6];
      end
    end
  end
endmodule

// File: ees_host.sv
/*
  bus master end: byte-level two-wire engine commanded through two AXI4-Lite registers.
  assumes one AXI4-Lite master on aclk; the slave only answers, scl is made here.
*/
`timescale 1ns/10ps
module ees_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // two-wire link
  ees_link_if.master link
);
  import ees_pkg::*;
  localparam logic [4:0] QTR_LAST = 5'(SCL_QTR_CYC - 1);

  // ***************
  // state
  // ***************
  ees_hstate_type state_r;
  logic aw_held_r, w_held_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] cmd_r;
  logic [1:0] sda_s_r;
  logic [4:0] qcnt_r;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r, rx_r;
  logic nack_r, done_r, scl_r, sda_oe_r;

  // ***************
  // decoding
  // ***************
  wire sda_in = sda_s_r[1];
  wire tick = (qcnt_r == QTR_LAST);
  wire busy = (state_r != H_IDLE);
  wire wr_do = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_cmd = wr_do && (awaddr_r == REG_CMD);
  wire wr_stat = wr_do && (awaddr_r == REG_STAT);
  wire go = wr_cmd && (wstrb_r[1:0] == 2'h3) && !busy;
  // while busy a command write is answered but dropped
  wire rd_hit = (s_axi_araddr == REG_CMD) || (s_axi_araddr == REG_STAT);
  wire [31:0] stat_w = {16'h0000, rx_r, 5'h00, done_r, nack_r, busy};
  wire is_rd = cmd_r[CMD_READ_BIT];
  wire bit_drive = (bit_r < 4'h8) ? (!is_rd && !tx_r[7]) : (is_rd && cmd_r[CMD_ACK_BIT]);
  wire done_set = (state_r == H_DONE);

  assign link.scl = scl_r;
  assign link.m_sda_oe = sda_oe_r;
  assign link.m_sda_o = 1'b0;

  // ***************
  // axi4-lite slave
  // ***************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_cmd || wr_stat) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata <= (s_axi_araddr == REG_CMD) ? cmd_r : ((s_axi_araddr == REG_STAT) ? stat_w : 32'h0000_0000);
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ***************
  // link engine
  // ***************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= H_IDLE;
      sda_s_r <= 2'h3;
      cmd_r <= CMD_RST;
      qcnt_r <= 5'h00;
      phase_r <= 2'h0;
      bit_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      nack_r <= 1'b0;
      done_r <= 1'b0;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0;
    end else begin
      sda_s_r <= {sda_s_r[0], link.sda};
      qcnt_r <= (tick || !busy) ? 5'h00 : qcnt_r + 5'h01;
      if (done_set) begin
        done_r <= 1'b1;
      end else if (wr_stat && wstrb_r[0] && wdata_r[STAT_DONE_BIT]) begin
        done_r <= 1'b0;
      end
      case (state_r)
        H_IDLE: begin
          if (go) begin
            cmd_r <= wdata_r;
            tx_r <= wdata_r[7:0];
            phase_r <= 2'h0;
            bit_r <= 4'h0;
            state_r <= wdata_r[CMD_START_BIT] ? H_START : H_BIT;
          end
        end
        H_START: begin
          if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_oe_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_oe_r <= 1'b1;
              default: begin
                scl_r <= 1'b0;
                state_r <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_oe_r <= bit_drive;
              2'h1: scl_r <= 1'b1;
              2'h2: begin
                if (bit_r < 4'h8) begin
                  rx_r <= {rx_r[6:0], sda_in};
                end else begin
                  nack_r <= sda_in;
                end
              end
              default: begin
                scl_r <= 1'b0;
                tx_r <= {tx_r[6:0], 1'b0};
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h8) begin
                  state_r <= cmd_r[CMD_STOP_BIT] ? H_STOP : H_DONE;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (phase_r)
              2'h0: sda_oe_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_oe_r <= 1'b0;
              default: state_r <= H_DONE;
            endcase
          end
        end
        H_DONE: begin
          sda_oe_r <= 1'b0;
          state_r <= H_IDLE;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end
endmodule

// File: ees_link_asserts.sv
/*
  link checks between the two ends, placed beside the link in the bench.
  assumes one aclk domain and link wires far slower than aclk.
*/
`timescale 1ns/10ps
module ees_link_asserts #(
  parameter int unsigned PROG_CYC = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  input wire logic scl,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic sda,
  // slave status
  input wire logic prog_busy
);
  import ees_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // frame tracking
  // ****************
  logic scl_q_r, sda_q_r, frame_r, first_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  int unsigned busy_r;
  wire start_w = scl && scl_q_r && sda_q_r && !sda;
  wire stop_w = scl && scl_q_r && !sda_q_r && sda;
  wire rise_w = scl && !scl_q_r;
  wire wrap_w = cnt_r == 4'h9;
  wire alien_w = sh_r[7:4] != TYPE_MEM && sh_r[7:4] != TYPE_PROT;
  // counts rises since start: 1..8 data, 9 ack
  always_ff @(posedge aclk) begin
    scl_q_r <= scl;
    sda_q_r <= sda;
    busy_r <= prog_busy ? busy_r + 1 : 0;
    if (rise_w) begin
      cnt_r <= wrap_w ? 4'h1 : cnt_r + 4'h1;
      first_r <= first_r && !wrap_w;
      sh_r <= cnt_r < 4'h8 ? {sh_r[6:0], sda} : sh_r;
    end
    if (start_w || stop_w) frame_r <= start_w;
    if (start_w) cnt_r <= 4'h0;
    if (start_w || !aresetn) first_r <= aresetn;
    if (!aresetn) frame_r <= 1'h0;
  end
  // ****************
  // properties
  // ****************
  a_no_fight: assert property (scl |-> !(s_sda_oe && m_sda_oe))
    else $error("both ends pull sda while scl high");
  a_slave_still: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave sda moved while scl high");
  a_idle_quiet: assert property (!frame_r |-> !s_sda_oe)
    else $error("slave drove sda outside a frame");
  a_busy_quiet: assert property (prog_busy |-> !s_sda_oe)
    else $error("slave drove sda while programming");
  a_alien_quiet: assert property (first_r && wrap_w && alien_w |-> !s_sda_oe)
    else $error("slave answered a foreign type");
  a_ack_slot: assert property ($rose(s_sda_oe) && first_r |-> cnt_r == 4'h8 || (wrap_w && sh_r[0]))
    else $error("slave pulled sda outside the ack slot");
  a_prog_on_stop: assert property ($rose(prog_busy) |-> scl && sda && !$past(sda, 8))
    else $error("programming began without a stop");
  a_prog_length: assert property ($fell(prog_busy) |-> busy_r + 1 >= PROG_CYC && busy_r <= PROG_CYC + 1)
    else $error("programming window length wrong");
endmodule

// File: tb.sv
/*
  bench: axi4-lite tasks command the host, the slave answers across the link.
  assumes ees_pkg; programming time is cut short so that waits stay brief.
*/
`timescale 1ns/10ps
module tb;
  import ees_pkg::*;
  // ****************
  // setup
  // ****************
  localparam int unsigned PCYC = 2000;
  localparam logic [2:0] CS = 3'h5;
  localparam logic [7:0] SW = {TYPE_MEM, CS, 1'h0};
  localparam logic [7:0] SR = {TYPE_MEM, CS, 1'h1};
  localparam logic [7:0] PW = {TYPE_PROT, CS, 1'h0};
  logic aclk = 0, aresetn = 0, wl_en = 1, busy;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd, st;
  logic [1:0] bresp, rresp, rsp;
  logic [9:0] wsh = 0;
  logic [7:0] pg [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic [7:0] bad [3] = '{8'h50, {TYPE_MEM, ~CS, 1'h0}, PW};
  int n_fail = 0, checks_done = 0, cyc = 0;
  tri1 wlock;
  // a released lock pin floats to the pull-up
  assign wlock = wl_en ? 1'h0 : 1'hz;
  always #25 aclk = ~aclk;
  ees_link_if link();
  ees_host i_ees_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.master));
  ees_dev #(.PROG_CYC(PCYC)) i_ees_dev (.aclk(aclk), .aresetn(aresetn), .link(link.slave),
    .chip_select_inputs(CS), .write_lock_pin(wlock), .prog_busy(busy));
  ees_link_asserts #(.PROG_CYC(PCYC)) i_ees_link_asserts (.aclk(aclk), .aresetn(aresetn), .scl(link.scl),
    .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe), .sda(link.sda), .prog_busy(busy));
  always @(posedge link.scl) wsh <= {wsh[8:0], link.sda};
  // ****************
  // tasks
  // ****************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  // one link byte: order, wait for done, clear the sticky done flag
  task automatic cmd(input logic [31:0] c);
    axi_wr(REG_CMD, c);
    do axi_rd(REG_STAT); while (rd[STAT_DONE_BIT] !== 1'h1);
    st = rd;
    axi_wr(REG_STAT, 32'h0000_0004);
  endtask
  // a stop adds one more scl rise, so the captured bits sit one place higher
  task automatic tx(input logic [7:0] b, input logic s, input logic p, input logic nk);
    cmd({20'h0_0000, 2'h0, p, s, b});
    chk("wire byte", 32'(p ? wsh[9:2] : wsh[8:1]), 32'(b));
    chk("wire ack", 32'(p ? wsh[1] : wsh[0]), 32'(nk));
    chk("nack flag", 32'(st[STAT_NACK_BIT]), 32'(nk));
  endtask
  task automatic rx(input logic a, input logic p, input logic [7:0] e);
    cmd({20'h0_0000, a, 1'h1, p, 1'h0, 8'h00});
    chk("read byte", 32'(st[STAT_RX_LSB +: 8]), 32'(e));
  endtask
  task automatic wr3(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] d, input logic nk);
    tx(sel, 1'h1, 1'h0, 1'h0);
    tx(a, 1'h0, 1'h0, 1'h0);
    tx(d, 1'h0, 1'h1, nk);
    chk("prog busy", 32'(busy), 32'(!nk));
  endtask
  task automatic rdat(input logic [7:0] a, input logic [7:0] e);
    tx(SW, 1'h1, 1'h0, 1'h0);
    tx(a, 1'h0, 1'h0, 1'h0);
    tx(SR, 1'h1, 1'h0, 1'h0);
    rx(1'h0, 1'h1, e);
  endtask
  task automatic idle();
    while (busy !== 1'h0) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    chk("idle line", 32'({link.scl, link.sda}), 32'h3);
    axi_rd(REG_CMD);
    chk("cmd reset", rd, CMD_RST);
    axi_rd(4'h8);
    chk("unmapped read", 32'(rsp), 32'(RESP_SLVERR));
    axi_wr(4'hC, 32'h0000_0001);
    chk("unmapped write", 32'(rsp), 32'(RESP_SLVERR));
    wr3(SW, 8'h10, 8'h5A, 1'h0);
    tx(SW, 1'h1, 1'h1, 1'h1);
    idle();
    tx(SW, 1'h1, 1'h1, 1'h0);
    rdat(8'h10, 8'h5A);
    // four bytes from the row's last but two: the last one wraps to the row start
    tx(SW, 1'h1, 1'h0, 1'h0);
    tx(8'h2D, 1'h0, 1'h0, 1'h0);
    for (int i = 0; i < 4; i++) begin
      tx(pg[i], 1'h0, 1'(i == 3), 1'h0);
    end
    idle();
    rdat(8'h2D, pg[0]);
    tx(SR, 1'h1, 1'h0, 1'h0);
    rx(1'h1, 1'h0, pg[1]);
    rx(1'h0, 1'h1, pg[2]);
    rdat(8'h20, pg[3]);
    for (int i = 0; i < 3; i++) begin
      tx(bad[i], 1'h1, 1'h1, 1'(i < 2));
    end
    wr3(PW, 8'h00, 8'h81, 1'h0);
    idle();
    tx({TYPE_PROT, CS, 1'h1}, 1'h1, 1'h0, 1'h0);
    rx(1'h0, 1'h1, 8'h81);
    wl_en <= 1'h0;
    wr3(SW, 8'h20, 8'hC3, 1'h1);
    wr3(SW, 8'h10, 8'h3C, 1'h0);
    idle();
    wr3(PW, 8'h00, 8'h00, 1'h1);
    rdat(8'h20, pg[3]);
    wl_en <= 1'h1;
    wr3(SW, 8'h20, 8'hC3, 1'h0);
    idle();
    rdat(8'h20, 8'hC3);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    chk("slave off in reset", 32'(link.s_sda_oe), 32'h0);
    aresetn <= 1'h1;
    repeat (4) @(posedge aclk);
    rdat(8'h10, 8'h3C);
    give_verdict();
  end
endmodule
